// file: verilog/tic_timer_irq_ctrl.sv
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Timer 0 run bit: one enables counting, zero stops it.
// - Timer 0 overflow sets its overflow flag.
// - Timer 0 flag cleared by software write or on vectoring.
// - Ext irq 1 pending set on configured edge or level.
// - Ext irq 1 pending cleared by software; vector clears only in edge mode.
// - Type select 0 is level, 1 is edge detection.
// - Input active sense comes from separate polarity bit.
// - Timer 0 counts when run and (gate zero or irq 0 active).
// - Timer 1 run and overflow behave like timer 0.
`include "tic_regs.svh"
module tic_timer_irq_ctrl
  import tic_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer overflow events, one-cycle pulses from the counters
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  // External interrupt pins
  input wire logic extirq0_input,
  input wire logic extirq1_input,
  // CPU vectoring acknowledge pulses
  input wire tic_vec_t vec_ack,
  // Counter enables toward the timers
  output logic timer0_count_en,
  output logic timer1_count_en,
  // Interrupt requests toward the CPU
  output tic_evt_t irq_req,
  // Summary interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  // Control register fields owned by software
  logic timer0_run_bit;
  logic timer1_run_bit;
  logic extirq0_type_select;
  logic extirq1_type_select;
  // Config, sticky status and mask words
  logic [3:0] cfg_r;
  logic [3:0] stat_r;
  logic [3:0] mask_r;
  // Flags shared by hardware, software and vectoring
  logic timer0_overflow_flag;
  logic timer1_overflow_flag;
  logic extirq0_pending_flag;
  logic extirq1_pending_flag;
  // Detector results
  logic x0_active;
  logic x1_active;
  logic x0_detect;
  logic x1_detect;
  // Register bus decode
  logic wr_ctrl;
  logic wr_cfg;
  logic wr_stat;
  logic wr_mask;
  logic access;
  logic [7:0] ctrl_rd;
  logic [31:0] rd_nxt;
  logic err_nxt;
  tic_evt_t evt;
  tic_apb_st_t st_r;

  // Decode of an aligned register address
  // Only exact matches hit, so the low two address bits must be zero
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    addr_hit = (a == ADDR_W'(off));
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////
  // APB handshake: one wait-free access phase
  assign access = psel & penable & (st_r == TIC_ACCESS);
  // Access only counts after a setup seen here, so a master that keeps
  // penable high across transfers cannot make a write land twice

  // Setup tracking so a write lands only once per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= TIC_IDLE;
    end else begin
      case (st_r)
        TIC_IDLE: begin
          if (psel && !penable) begin
            st_r <= TIC_ACCESS;
          end
        end
        TIC_ACCESS: begin
          st_r <= TIC_IDLE;
        end
        default: begin
          st_r <= TIC_IDLE;
        end
      endcase
    end
  end

  // Write strobes
  // Unmapped addresses raise no strobe, so such writes are dropped
  assign wr_ctrl = access & pwrite & addr_hit(paddr, `TIC_ADDR_CTRL);
  assign wr_cfg = access & pwrite & addr_hit(paddr, `TIC_ADDR_CFG);
  assign wr_stat = access & pwrite & addr_hit(paddr, `TIC_ADDR_IRQ_STAT);
  assign wr_mask = access & pwrite & addr_hit(paddr, `TIC_ADDR_IRQ_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Software-owned control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_run_bit <= 1'(`TIC_CTRL_RST >> `TIC_BIT_T0_RUN);
      timer1_run_bit <= 1'b0;
      extirq0_type_select <= 1'b0;
      extirq1_type_select <= 1'b0;
    end else if (wr_ctrl) begin
      timer0_run_bit <= pwdata[`TIC_BIT_T0_RUN];
      timer1_run_bit <= pwdata[`TIC_BIT_T1_RUN];
      extirq0_type_select <= pwdata[`TIC_BIT_X0_TYPE];
      extirq1_type_select <= pwdata[`TIC_BIT_X1_TYPE];
    end
  end

  // Polarity and gate configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= `TIC_CFG_RST;
    end else if (wr_cfg) begin
      cfg_r <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // External interrupt detectors
  // Changing the sense can make a standing level look like a fresh edge;
  // software should clear the pending flag after reconfiguring
  tic_extirq_det u_det0 (
    .pclk(pclk),
    .presetn(presetn),
    .irq_in(extirq0_input),
    .polarity(cfg_r[`TIC_BIT_X0_POL]),
    .type_edge(extirq0_type_select),
    .active(x0_active),
    .detect(x0_detect)
  );

  tic_extirq_det u_det1 (
    .pclk(pclk),
    .presetn(presetn),
    .irq_in(extirq1_input),
    .polarity(cfg_r[`TIC_BIT_X1_POL]),
    .type_edge(extirq1_type_select),
    .active(x1_active),
    .detect(x1_detect)
  );

  ////////////////////////////////////////////////////////////////////////
  // Flags of the control register
  // A control write stores the written value, so software may clear or set
  // Vectoring clears a pending flag only in edge mode; a level keeps it set
  tic_flag u_t0f (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(timer0_overflow),
    .sw_wr(wr_ctrl),
    .sw_val(pwdata[`TIC_BIT_T0_OVF]),
    .vec_clr(vec_ack.timer0),
    .flag_r(timer0_overflow_flag)
  );

  tic_flag u_t1f (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(timer1_overflow),
    .sw_wr(wr_ctrl),
    .sw_val(pwdata[`TIC_BIT_T1_OVF]),
    .vec_clr(vec_ack.timer1),
    .flag_r(timer1_overflow_flag)
  );

  tic_flag u_x0f (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(x0_detect),
    .sw_wr(wr_ctrl),
    .sw_val(pwdata[`TIC_BIT_X0_PEND]),
    .vec_clr(vec_ack.extirq0 & extirq0_type_select),
    .flag_r(extirq0_pending_flag)
  );

  tic_flag u_x1f (
    .pclk(pclk),
    .presetn(presetn),
    .hw_set(x1_detect),
    .sw_wr(wr_ctrl),
    .sw_val(pwdata[`TIC_BIT_X1_PEND]),
    .vec_clr(vec_ack.extirq1 & extirq1_type_select),
    .flag_r(extirq1_pending_flag)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sticky event status, write one to clear, set wins
  // Status keeps raw events and, unlike the flags, survives vectoring
  assign evt = '{t1_ovf: timer1_overflow, x1: x1_detect, t0_ovf: timer0_overflow,
                 x0: x0_detect};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= `TIC_STAT_RST;
    end else begin
      stat_r <= evt | (stat_r & ~(wr_stat ? pwdata[3:0] : 4'h0));
    end
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `TIC_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs toward timers and CPU
  // One cycle of lag from a run, gate or pin change to the timer enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0_count_en <= 1'b0;
      timer1_count_en <= 1'b0;
    end else begin
      timer0_count_en <= timer0_run_bit & (~cfg_r[`TIC_BIT_T0_GATE] | x0_active);
      timer1_count_en <= timer1_run_bit & (~cfg_r[`TIC_BIT_T1_GATE] | x1_active);
    end
  end

  // Pending requests and summary interrupt
  // Both trail the flags and status by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_req <= '0;
      irq <= 1'b0;
    end else begin
      irq_req <= '{t1_ovf: timer1_overflow_flag, x1: extirq1_pending_flag,
                   t0_ovf: timer0_overflow_flag, x0: extirq0_pending_flag};
      irq <= |(stat_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux
  // Unused upper bits read as zero
  assign ctrl_rd = {timer1_overflow_flag, timer1_run_bit, timer0_overflow_flag,
                    timer0_run_bit, extirq1_pending_flag, extirq1_type_select,
                    extirq0_pending_flag, extirq0_type_select};

  always_comb begin
    rd_nxt = 32'h0000_0000;
    err_nxt = 1'b0;
    if (addr_hit(paddr, `TIC_ADDR_CTRL)) begin
      rd_nxt = {24'h00_0000, ctrl_rd};
    end else if (addr_hit(paddr, `TIC_ADDR_CFG)) begin
      rd_nxt = {28'h000_0000, cfg_r};
    end else if (addr_hit(paddr, `TIC_ADDR_IRQ_STAT)) begin
      rd_nxt = {28'h000_0000, stat_r};
    end else if (addr_hit(paddr, `TIC_ADDR_IRQ_MASK)) begin
      rd_nxt = {28'h000_0000, mask_r};
    end else begin
      err_nxt = 1'b1;
    end
  end

  // Answer registered in the setup cycle, shown in the access phase
  // Writes return zero data; an unmapped address raises pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
      pready <= 1'b1;
      pslverr <= err_nxt;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : tic_timer_irq_ctrl

// file: verilog/tic_regs.svh
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH
// Byte addresses of the APB registers
`define TIC_ADDR_CTRL 12'h000
`define TIC_ADDR_CFG 12'h004
`define TIC_ADDR_IRQ_STAT 12'h008
`define TIC_ADDR_IRQ_MASK 12'h00c
// Control register bit positions
`define TIC_BIT_T1_OVF 7
`define TIC_BIT_T1_RUN 6
`define TIC_BIT_T0_OVF 5
`define TIC_BIT_T0_RUN 4
`define TIC_BIT_X1_PEND 3
`define TIC_BIT_X1_TYPE 2
`define TIC_BIT_X0_PEND 1
`define TIC_BIT_X0_TYPE 0
// Config register bit positions
`define TIC_BIT_X0_POL 0
`define TIC_BIT_X1_POL 1
`define TIC_BIT_T0_GATE 2
`define TIC_BIT_T1_GATE 3
// Reset values
`define TIC_CTRL_RST 8'h00
`define TIC_CFG_RST 4'h0
`define TIC_STAT_RST 4'h0
`define TIC_MASK_RST 4'h0
`endif

// file: verilog/tic_pkg.sv
package tic_pkg;
  // Vectoring acknowledge from the CPU, one pulse bit per source
  typedef struct packed {
    logic timer1;
    logic extirq1;
    logic timer0;
    logic extirq0;
  } tic_vec_t;
  // Per-source event group
  typedef struct packed {
    logic t1_ovf;
    logic x1;
    logic t0_ovf;
    logic x0;
  } tic_evt_t;
  // APB slave phases
  typedef enum logic [1:0] {
    TIC_IDLE,
    TIC_ACCESS
  } tic_apb_st_t;
endpackage : tic_pkg

// file: verilog/tic_extirq_det.sv
`timescale 1ns/1ps
// Detects the configured level or edge of one external interrupt input
module tic_extirq_det (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin and configuration
  input wire logic irq_in,
  input wire logic polarity,
  input wire logic type_edge,
  // Results
  output logic active,
  output logic detect
);
  logic prev_r;

  // Sense applied to the raw pin
  assign active = polarity ? irq_in : ~irq_in;

  // Previous active state for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= active;
    end
  end

  // Level when type is 0, inactive-to-active edge when type is 1
  assign detect = type_edge ? (active & ~prev_r) : active;
endmodule : tic_extirq_det

// file: verilog/tic_flag.sv
`timescale 1ns/1ps
// Hardware-set flag with software write and automatic vector clear
module tic_flag (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Set and clear sources
  input wire logic hw_set,
  input wire logic sw_wr,
  input wire logic sw_val,
  input wire logic vec_clr,
  // Flag
  output logic flag_r
);
  // Set wins over any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= 1'b0;
    end else if (hw_set) begin
      flag_r <= 1'b1;
    end else if (sw_wr) begin
      flag_r <= sw_val;
    end else if (vec_clr) begin
      flag_r <= 1'b0;
    end
  end
endmodule : tic_flag

// file: verif/tic_timer_irq_ctrl_assertions.sv
`timescale 1ns/1ps
// Port-level checker for the timer and external interrupt control block
module tic_timer_irq_ctrl_assertions
  import tic_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Events and outputs
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic extirq0_input,
  input wire logic extirq1_input,
  input wire tic_vec_t vec_ack,
  input wire logic timer0_count_en,
  input wire logic timer1_count_en,
  input wire tic_evt_t irq_req,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control write that lands at this edge
  wire logic wr_ctrl = psel && penable && pready && pwrite && (paddr == '0);
  property p_t0_set; timer0_overflow |-> ##2 irq_req.t0_ovf; endproperty
  a_t0_set: assert property (p_t0_set) else $error("t0 flag not set");
  property p_t1_set; timer1_overflow |-> ##2 irq_req.t1_ovf; endproperty
  a_t1_set: assert property (p_t1_set) else $error("t1 flag not set");
  property p_t0_vec;
    vec_ack.timer0 && !timer0_overflow && !psel
      |-> ##2 (!irq_req.t0_ovf || $past(timer0_overflow) || $past(psel));
  endproperty
  a_t0_vec: assert property (p_t0_vec) else $error("t0 flag kept");
  property p_run0_off; wr_ctrl && !pwdata[4] |-> ##2 !timer0_count_en; endproperty
  a_run0_off: assert property (p_run0_off) else $error("t0 still counts");
  property p_run1_off; wr_ctrl && !pwdata[6] |-> ##2 !timer1_count_en; endproperty
  a_run1_off: assert property (p_run1_off) else $error("t1 still counts");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("ready held");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("stray slave error");
endmodule : tic_timer_irq_ctrl_assertions

bind tic_timer_irq_ctrl tic_timer_irq_ctrl_assertions #(.ADDR_W(ADDR_W))
  i_tic_timer_irq_ctrl_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer0_overflow(timer0_overflow),
  .timer1_overflow(timer1_overflow), .extirq0_input(extirq0_input),
  .extirq1_input(extirq1_input), .vec_ack(vec_ack), .timer0_count_en(timer0_count_en),
  .timer1_count_en(timer1_count_en), .irq_req(irq_req), .irq(irq));

// file: verif/tic_cpu_vec_model.sv
`timescale 1ns/1ps
// CPU vectoring: one pulse per enabled request, then waits out the copy lag
module tic_cpu_vec_model
  import tic_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests and enables
  input wire tic_evt_t irq_req,
  input wire logic [3:0] vec_en,
  // Acknowledge
  output tic_vec_t vec_ack
);
  logic [3:0] ack_d_r;
  // Pulse generation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_ack <= '0;
      ack_d_r <= 4'h0;
    end else begin
      vec_ack <= tic_vec_t'(irq_req & vec_en & ~vec_ack & ~ack_d_r);
      ack_d_r <= vec_ack;
    end
  end
endmodule : tic_cpu_vec_model

// file: verif/test_timer_and_ext_irq_control.sv
`timescale 1ns/1ps
module test_timer_and_ext_irq_control
  import tic_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, t0o = 1'b0, t1o = 1'b0, x0 = 1'b1, x1 = 1'b1, irq;
  logic [3:0] vec_en = 4'h0;
  logic t0en, t1en;
  tic_vec_t vec_ack;
  tic_evt_t irq_req;
  int errors = 0;
  int compares = 0;
  tic_timer_irq_ctrl i_tic_timer_irq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timer0_overflow(t0o), .timer1_overflow(t1o),
    .extirq0_input(x0), .extirq1_input(x1), .vec_ack(vec_ack), .timer0_count_en(t0en),
    .timer1_count_en(t1en), .irq_req(irq_req), .irq(irq));
  tic_cpu_vec_model i_tic_cpu_vec_model (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
    .vec_en(vec_en), .vec_ack(vec_ack));
  // Clock
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdc
  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    cyc(3000);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    end_of_test();
  end
  // Tests
  initial begin
    cyc(8);
    presetn <= 1'b1;
    cyc(1);
    rdc(12'h000, 32'h0);
    rdc(12'h004, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h00c, 32'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(er, 32'h1);
    $display("test reset done");
    apb(1'b1, 12'h000, 32'h50);
    cyc(2);
    chk({t1en, t0en}, 32'h3);
    apb(1'b1, 12'h004, 32'h4);
    cyc(2);
    chk({t1en, t0en}, 32'h2);
    x0 <= 1'b0;
    cyc(3);
    chk({t1en, t0en}, 32'h3);
    rdc(12'h000, 32'h52);
    x0 <= 1'b1;
    apb(1'b1, 12'h000, 32'h0);
    cyc(2);
    chk({t1en, t0en}, 32'h0);
    rdc(12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'hf);
    $display("test run done");
    apb(1'b1, 12'h00c, 32'h2);
    t0o <= 1'b1;
    cyc(1);
    t0o <= 1'b0;
    cyc(2);
    chk(irq, 32'h1);
    chk(irq_req, 32'h2);
    rdc(12'h000, 32'h20);
    vec_en <= 4'h2;
    cyc(5);
    rdc(12'h000, 32'h0);
    chk(irq, 32'h1);
    apb(1'b1, 12'h008, 32'h2);
    cyc(2);
    chk(irq, 32'h0);
    vec_en <= 4'h0;
    t1o <= 1'b1;
    cyc(1);
    t1o <= 1'b0;
    cyc(2);
    chk(irq, 32'h0);
    rdc(12'h008, 32'h8);
    rdc(12'h000, 32'h80);
    apb(1'b1, 12'h000, 32'h0);
    rdc(12'h000, 32'h0);
    $display("test overflow done");
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b1, 12'h000, 32'h4);
    rdc(12'h000, 32'h4);
    x1 <= 1'b0;
    cyc(2);
    x1 <= 1'b1;
    cyc(2);
    rdc(12'h000, 32'hc);
    vec_en <= 4'h4;
    cyc(5);
    rdc(12'h000, 32'h4);
    apb(1'b1, 12'h000, 32'h0);
    rdc(12'h000, 32'h8);
    x1 <= 1'b0;
    cyc(5);
    rdc(12'h000, 32'h8);
    vec_en <= 4'h0;
    x1 <= 1'b0;
    apb(1'b1, 12'h000, 32'h0);
    rdc(12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h004, 32'h3);
    rdc(12'h000, 32'h3);
    vec_en <= 4'h1;
    cyc(5);
    rdc(12'h000, 32'h1);
    $display("test extirq done");
    end_of_test();
  end
endmodule : test_timer_and_ext_irq_control
